// ==== rtl/spi_cfg_pkg.sv ====
// Shared constants for the serial configuration port and its master.
// Assumes both ends run on one 100 MHz system clock.
package spi_cfg_pkg;
    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int ADDR_BITS = 7;
    localparam int REG_COUNT = 128;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [6:0] MAX_BLOCK_BYTES = 7'h7F;
    localparam logic [6:0] FIRST_ILLEGAL_ADDR = 7'h78;
    localparam logic [6:0] MODE_REG_ADDR = 7'h1F;
    localparam int FOUR_WIRE_BIT = 6;
    localparam int READ_EDGE_BIT = 7;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SCLK_MAX_MHZ = 20;
    // Tick compare value in system cycles; each serial clock half period lasts one cycle more.
    // Slower than the pin limit: read data makes a round trip through
    // two synchronisers and an edge detector before the master samples.
    localparam int SCLK_HALF_CYCLES = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1)
                                      / (2 * SCLK_MAX_MHZ) + 4;
    localparam logic [3:0] SCLK_HALF = 4'(SCLK_HALF_CYCLES);
endpackage

// ==== rtl/spi_cfg_if.sv ====
// Serial link wires between the configuration master and the port.
// The shared data wire is resolved here from the two output enables.
`timescale 1ns/1ps
`default_nettype none
interface spi_cfg_if;
    logic serial_clk;
    logic chip_select_low;
    logic mst_data_out;
    logic mst_data_oe_n;
    logic dev_data_out;
    logic dev_data_oe_n;
    logic serial_data_io;
    logic serial_data_out;
    // Pull-up keeps the shared wire defined when nobody drives
    assign serial_data_io = !dev_data_oe_n ? dev_data_out :
                            (!mst_data_oe_n ? mst_data_out : 1'b1);
    modport device (input serial_clk, input chip_select_low,
                    input serial_data_io, output dev_data_out,
                    output dev_data_oe_n, output serial_data_out);
    modport master (output serial_clk, output chip_select_low,
                    output mst_data_out, output mst_data_oe_n,
                    input serial_data_io, input serial_data_out);
endinterface
`default_nettype wire

// ==== rtl/spi_cfg_slave.sv ====
// Serial configuration port: slave end holding a 128-byte register file.
// Assumes the link pins are asynchronous and sampled by clk_in.
//
// Functional notes
// - Three-wire mode after reset.
// - Register bit picks three or four wire.
// - Transfers are whole bytes, master started.
// - Deselected: data pin released, activity ignored.
// - Input sampled on serial clock rise.
// - Read data edge set by register bit.
// - Select fall starts transfer, pin input.
// - First byte: direction flag, seven address bits.
// - Everything shifted least significant bit first.
// - Read loads register, shifts out next byte.
// - Master stops only on byte boundaries.
// - Reads auto-increment address per byte.
// - Block read at most 127 bytes.
// - Write commits byte at eighth bit.
// - Writes auto-increment seven-bit address.
// - Master avoids addresses 0x78 and up.
// - Master enables outputs in separate transfer.
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_slave (
    input wire logic clk_in,             // System clock
    input wire logic nrst_in,            // Async reset, active low
    spi_cfg_if.device link,              // Serial link
    input wire logic [6:0] peek_addr_in, // User-side register read address
    output logic [7:0] peek_data_out,    // Register contents at peek_addr_in
    output logic four_wire_out,          // Four-wire mode selected
    output logic wr_strobe_out           // One-cycle pulse on register write
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int REG_COUNT = spi_cfg_pkg::REG_COUNT;
    typedef struct packed {
        logic [1:0] sclk_sync;
        logic [1:0] cs_sync;
        logic [1:0] din_sync;
        logic sclk_last;
        logic [2:0] bit_cnt;
        logic cmd_done;
        logic is_read;
        logic [6:0] addr;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic [6:0] byte_cnt;
        logic drive;
        logic dout;
        logic wr_pulse;
        logic [REG_COUNT*8-1:0] regs;
    } state_s;
    state_s state_reg, state_next;
    logic sclk_rise, sclk_fall, cs_active, four_wire, read_edge;
    logic [7:0] byte_in;

    function automatic logic [7:0] reg_at(input logic [REG_COUNT*8-1:0] r,
                                          input logic [6:0] a);
        reg_at = r[a*8 +: 8];
    endfunction

    // Synchronised link levels and edges; only stage 1 is used
    assign sclk_rise = state_reg.sclk_sync[1] & ~state_reg.sclk_last;
    assign sclk_fall = ~state_reg.sclk_sync[1] & state_reg.sclk_last;
    assign cs_active = ~state_reg.cs_sync[1];
    assign four_wire = state_reg.regs[spi_cfg_pkg::MODE_REG_ADDR*8
                                      + spi_cfg_pkg::FOUR_WIRE_BIT];
    assign read_edge = state_reg.regs[spi_cfg_pkg::MODE_REG_ADDR*8
                                      + spi_cfg_pkg::READ_EDGE_BIT];
    // LSB arrives first, so new bits enter at the top
    assign byte_in = {state_reg.din_sync[1], state_reg.shift_in[7:1]};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.sclk_sync = {state_reg.sclk_sync[0], link.serial_clk};
        state_next.cs_sync = {state_reg.cs_sync[0], link.chip_select_low};
        state_next.din_sync = {state_reg.din_sync[0], link.serial_data_io};
        state_next.sclk_last = state_reg.sclk_sync[1];
        state_next.wr_pulse = 1'b0;
        if (!cs_active) begin
            // Idle while deselected; next frame starts with a command
            state_next.bit_cnt = 3'h0;
            state_next.cmd_done = 1'b0;
            state_next.is_read = 1'b0;
            state_next.byte_cnt = 7'h00;
            state_next.drive = 1'b0;
        end else begin
            if (sclk_rise) begin
                // Sample input on the rising edge
                state_next.shift_in = byte_in;
                state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
                if (state_reg.bit_cnt == spi_cfg_pkg::LAST_BIT) begin
                    if (!state_reg.cmd_done) begin
                        // Byte is flag then address, LSB first
                        state_next.cmd_done = 1'b1;
                        state_next.is_read = byte_in[0];
                        state_next.addr = byte_in[7:1];
                        if (byte_in[0]) begin
                            // Load the addressed register for shifting
                            state_next.shift_out =
                                reg_at(state_reg.regs, byte_in[7:1]);
                            state_next.drive = 1'b1;
                        end
                    end else if (state_reg.is_read) begin
                        // Next read byte: advance address and reload; stop driving at the block limit
                        state_next.byte_cnt = state_reg.byte_cnt + 7'h1;
                        state_next.addr = state_reg.addr + 7'h1;
                        state_next.shift_out = reg_at(state_reg.regs,
                            state_reg.addr + 7'h1);
                        if (state_reg.byte_cnt + 7'h1 >=
                            spi_cfg_pkg::MAX_BLOCK_BYTES) begin
                            state_next.drive = 1'b0;
                        end
                    end else begin
                        // Commit payload on its eighth bit
                        state_next.regs[state_reg.addr*8 +: 8] = byte_in;
                        state_next.addr = state_reg.addr + 7'h1;
                        state_next.wr_pulse = 1'b1;
                    end
                end
            end
            // Output bit changes on the edge picked by read_edge.
            // The bit leaving is the old bit 0; at a byte's last rise the
            // reload above already holds the next register, so no shift.
            if (state_reg.is_read && state_reg.drive) begin
                if (read_edge && sclk_rise) begin
                    state_next.dout = state_reg.shift_out[0];
                    if (state_reg.bit_cnt != spi_cfg_pkg::LAST_BIT)
                        state_next.shift_out = state_reg.shift_out >> 1;
                end else if (!read_edge && sclk_fall) begin
                    state_next.dout = state_reg.shift_out[0];
                    state_next.shift_out = state_reg.shift_out >> 1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= '0;  // All registers 0 except the select and data synchronisers: three-wire mode
            state_reg.sclk_sync <= 2'h0;
            state_reg.cs_sync <= 2'h3;
            state_reg.din_sync <= 2'h3;
        end else begin
            state_reg <= state_next;
        end
    end

    // Pin drive: three-wire uses the shared pin, four-wire the output
    assign link.dev_data_out = state_reg.dout;
    assign link.dev_data_oe_n = ~(state_reg.drive & state_reg.is_read
                                  & cs_active & ~four_wire);
    assign link.serial_data_out = state_reg.dout;
    assign peek_data_out = reg_at(state_reg.regs, peek_addr_in);
    assign four_wire_out = four_wire;
    assign wr_strobe_out = state_reg.wr_pulse;
endmodule // spi_cfg_slave
`default_nettype wire

// ==== rtl/spi_cfg_master.sv ====
// Serial configuration master: issues one read or write byte transfer.
// Assumes the slave follows the byte-framed, LSB-first protocol.
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_master (
    input wire logic clk_in,            // System clock
    input wire logic nrst_in,           // Async reset, active low
    spi_cfg_if.master link,             // Serial link
    input wire logic start_in,          // Start a single-byte transfer
    input wire logic read_in,           // 1 read, 0 write
    input wire logic [6:0] addr_in,     // Register address
    input wire logic [7:0] wdata_in,    // Write payload
    input wire logic four_wire_in,      // Sample separate output pin
    input wire logic read_edge_in,      // Slave's read edge setting
    output logic busy_out,              // Transfer in progress
    output logic done_out,              // One-cycle pulse at end
    output logic [7:0] rdata_out        // Read result
);
    typedef enum logic [1:0] {
        IDLE = 2'b00, SHIFT = 2'b01, FINISH = 2'b10
    } phase_e;
    typedef struct packed {
        phase_e phase;
        logic [1:0] din_sync;
        logic [3:0] div;
        logic sclk;
        logic cs_n;
        logic [3:0] bit_cnt;
        logic [15:0] tx;
        logic [7:0] rx;
        logic rd;
        logic edge_rise;
        logic sec;
        logic done;
    } state_s;
    state_s state_reg, state_next;
    logic tick;
    assign tick = (state_reg.div == spi_cfg_pkg::SCLK_HALF);

    // ------------------------------------------------------------------
    // Sequencer; stops only on a byte boundary
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.din_sync = {state_reg.din_sync[0],
            four_wire_in ? link.serial_data_out : link.serial_data_io};
        state_next.done = 1'b0;
        state_next.div = tick ? 4'h0 : state_reg.div + 4'h1;
        unique case (state_reg.phase)
            IDLE: begin
                state_next.div = 4'h0;
                if (start_in && addr_in < spi_cfg_pkg::FIRST_ILLEGAL_ADDR)
                    begin
                    state_next.phase = SHIFT;
                    state_next.cs_n = 1'b0;
                    state_next.tx = {wdata_in, addr_in, read_in};
                    state_next.rd = read_in;
                    state_next.bit_cnt = 4'h0;
                    state_next.sec = 1'b0;
                    state_next.edge_rise = read_edge_in;
                end
            end
            SHIFT: if (tick) begin
                state_next.sclk = ~state_reg.sclk;
                if (!state_reg.sclk) begin
                    // Rising edge: slave samples; read data captured
                    // on rise when it changes on fall, else half later
                    if (state_reg.sec && !state_reg.edge_rise)
                        state_next.rx = {state_reg.din_sync[1],
                                         state_reg.rx[7:1]};
                end else begin
                    if (state_reg.sec && state_reg.edge_rise)
                        state_next.rx = {state_reg.din_sync[1],
                                         state_reg.rx[7:1]};
                    state_next.tx = state_reg.tx >> 1;
                    state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
                    if (state_reg.bit_cnt == 4'h7) begin
                        state_next.sec = 1'b1;
                    end
                    if (state_reg.bit_cnt == 4'hF)
                        state_next.phase = FINISH;
                end
            end
            FINISH: if (tick) begin
                state_next.cs_n = 1'b1;
                state_next.phase = IDLE;
                state_next.done = 1'b1;
            end
            default: state_next.phase = IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
            state_reg.cs_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.serial_clk = state_reg.sclk;
    assign link.chip_select_low = state_reg.cs_n;
    assign link.mst_data_out = state_reg.tx[0];
    // Release the shared pin while the slave answers a read. The release
    // comes one cycle after the eighth rise, so the slave still samples the
    // last address bit, and before the slave can turn the pin round.
    assign link.mst_data_oe_n = state_reg.cs_n
        | (state_reg.rd & (state_reg.sec
           | (state_reg.sclk & (state_reg.bit_cnt == 4'h7)
              & (state_reg.div != 4'h0))));
    assign busy_out = (state_reg.phase != IDLE);
    assign done_out = state_reg.done;
    assign rdata_out = state_reg.rx;
endmodule // spi_cfg_master
`default_nettype wire

// ==== sim/spi_cfg_properties.sv ====
// Concurrent checks on the serial link between master and port.
// Assumes every link signal is sampled by the one system clock.
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_properties (
    input wire logic clk_in,          // System clock
    input wire logic nrst_in,         // Async reset, active low
    input wire logic serial_clk,      // Serial clock
    input wire logic chip_select_low, // Select, active low
    input wire logic mst_data_out,    // Master data bit
    input wire logic mst_data_oe_n,   // Master enable, low drives
    input wire logic dev_data_out,    // Port data bit
    input wire logic dev_data_oe_n,   // Port enable, low drives
    input wire logic serial_data_io,  // Resolved shared wire
    input wire logic serial_data_out  // Separate output wire
);
    logic sclk_q;
    logic [7:0] rises;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // ------------------------------------------------------------
    // Helper: serial clock rises seen within the current frame
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_q <= 1'b0;
            rises <= 8'h00;
        end else begin
            sclk_q <= serial_clk;
            if (chip_select_low)
                rises <= 8'h00; // Cleared between frames
            else if (serial_clk && !sclk_q)
                rises <= rises + 8'h01;
        end
    end
    // ------------------------------------------------------------
    // Link properties
    // ------------------------------------------------------------
    a_desel_released: assert property (chip_select_low [*4] |-> dev_data_oe_n)
        else $error("port drives pin while deselected");
    a_release_at_end: assert property ($rose(chip_select_low) |-> ##[0:4] dev_data_oe_n)
        else $error("port keeps driving after deselect");
    a_start_as_input: assert property ($fell(chip_select_low) |-> dev_data_oe_n [*4])
        else $error("pin not an input at frame start");
    a_no_contention: assert property (!(!dev_data_oe_n && !mst_data_oe_n))
        else $error("both ends drive the shared wire");
    a_drive_after_cmd: assert property (!dev_data_oe_n && !chip_select_low |-> rises >= 8'h08)
        else $error("port drives before command byte ends");
    a_whole_bytes: assert property ($rose(chip_select_low) |-> rises == 8'h10)
        else $error("frame not two whole bytes");
    a_sclk_idle: assert property (chip_select_low |-> !serial_clk)
        else $error("serial clock not idle while deselected");
    a_data_stable: assert property ($rose(serial_clk) && !mst_data_oe_n |-> $stable(mst_data_out) && serial_data_io == mst_data_out)
        else $error("master data moves at sampling edge");
    // Main scenarios reached
    c_frame: cover property ($rose(chip_select_low) && rises == 8'h10);
    c_pin_read: cover property (!dev_data_oe_n && dev_data_out);
    c_sep_read: cover property (!chip_select_low && $changed(serial_data_out));
endmodule // spi_cfg_properties
`default_nettype wire

// ==== sim/spi_config_port_slave_tb.sv ====
// Self-checking bench joining the configuration master to the port.
// Assumes the design package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module spi_config_port_slave_tb;
    typedef struct packed {logic rd; logic fw; logic [6:0] addr; logic [7:0] val;} note_s;
    localparam int LIMIT = 40000;
    logic clk, nrst, start, rd, fw, redge, busy, done, four_wire, wr_strobe;
    logic [6:0] addr, peek_addr, a;
    logic [7:0] wdata, rdata, peek_data, d;
    logic [7:0] cmd_seen = 8'h00;
    logic [3:0] nb = 4'h0;
    logic sclk_q = 1'b0;
    logic drove = 1'b0;
    logic [7:0] mem [128];
    note_s notes [$];
    int miscompares = 0, n_checks = 0, cycles = 0, strobes = 0, writes = 0;
    spi_cfg_if spi_cfg_if_i ();
    spi_cfg_slave spi_cfg_slave_i (.clk_in(clk), .nrst_in(nrst), .link(spi_cfg_if_i),
        .peek_addr_in(peek_addr), .peek_data_out(peek_data),
        .four_wire_out(four_wire), .wr_strobe_out(wr_strobe));
    spi_cfg_master spi_cfg_master_i (.clk_in(clk), .nrst_in(nrst), .link(spi_cfg_if_i),
        .start_in(start), .read_in(rd), .addr_in(addr), .wdata_in(wdata),
        .four_wire_in(fw), .read_edge_in(redge), .busy_out(busy),
        .done_out(done), .rdata_out(rdata));
    spi_cfg_properties spi_cfg_properties_i (.clk_in(clk), .nrst_in(nrst),
        .serial_clk(spi_cfg_if_i.serial_clk), .chip_select_low(spi_cfg_if_i.chip_select_low),
        .mst_data_out(spi_cfg_if_i.mst_data_out), .mst_data_oe_n(spi_cfg_if_i.mst_data_oe_n),
        .dev_data_out(spi_cfg_if_i.dev_data_out), .dev_data_oe_n(spi_cfg_if_i.dev_data_oe_n),
        .serial_data_io(spi_cfg_if_i.serial_data_io),
        .serial_data_out(spi_cfg_if_i.serial_data_out));
    // ------------------------------------------------------------
    // Clock, wire watcher and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Command byte rebuilt from the wire, first bit lands in bit 0
    always @(posedge clk) begin
        sclk_q <= spi_cfg_if_i.serial_clk;
        if (spi_cfg_if_i.chip_select_low)
            nb <= 4'h0;
        else if (spi_cfg_if_i.serial_clk && !sclk_q && nb < 4'h8) begin
            cmd_seen <= {spi_cfg_if_i.serial_data_io, cmd_seen[7:1]};
            nb <= nb + 4'h1;
        end
        if (!spi_cfg_if_i.dev_data_oe_n)
            drove <= 1'b1;
        if (wr_strobe === 1'b1)
            strobes++;
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One framed transfer; the gap after done lets the monitor settle
    task automatic xfer(input logic r, input logic [6:0] ad, input logic [7:0] dv);
        int n;
        n = 0;
        @(negedge clk);
        drove = 1'b0;
        rd = r;
        addr = ad;
        wdata = dv;
        peek_addr = ad;
        start = 1'b1;
        notes.push_back({r, fw, ad, r ? mem[ad] : dv});
        if (!r) begin
            mem[ad] = dv;
            writes++;
        end
        @(negedge clk);
        start = 1'b0;
        while (done !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk(n < 1000, "transfer never finished");
        repeat (10) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // Result monitor: oldest note against each finished transfer
    // ------------------------------------------------------------
    initial begin
        note_s nt;
        forever begin
            @(negedge clk);
            if (done === 1'b1) begin
                nt = notes.pop_front();
                chk(cmd_seen === {nt.addr, nt.rd}, "command byte on wire");
                chk(drove === (nt.rd & ~nt.fw), "data pin direction");
                if (nt.rd)
                    chk(rdata === nt.val, "read data");
                else begin
                    repeat (6) @(negedge clk);
                    chk(peek_data === nt.val, "write commit");
                end
            end
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hF5A671A9));
        {nrst, start, rd, fw, redge} = 5'h00;
        addr = 7'h00;
        wdata = 8'h00;
        peek_addr = 7'h00;
        for (int i = 0; i < 128; i++)
            mem[i] = spi_cfg_pkg::REG_RESET_VALUE;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        chk(four_wire === 1'b0, "not three-wire after reset");
        chk(spi_cfg_if_i.dev_data_oe_n === 1'b1, "pin held after reset");
        // Reset values at the bottom of the usable space and at 0x76, one below its top
        xfer(1'b1, 7'h00, 8'h00);
        xfer(1'b1, 7'h76, 8'h00);
        // Every mode, then random write and read back within it
        for (int m = 0; m < 4; m++) begin
            xfer(1'b0, spi_cfg_pkg::MODE_REG_ADDR, {m[1], m[0], 6'h00});
            fw = m[0];
            redge = m[1];
            chk(four_wire === fw, "four-wire select");
            for (int k = 0; k < 4; k++) begin
                a = 7'($urandom % 32'h77);
                if (a == spi_cfg_pkg::MODE_REG_ADDR)
                    a = 7'h20;
                d = 8'($urandom);
                xfer(1'b0, a, d);
                xfer(1'b1, a, 8'h00);
            end
            xfer(1'b1, spi_cfg_pkg::MODE_REG_ADDR, 8'h00);
        end
        // Output enables go last, in a transfer of their own
        xfer(1'b0, 7'h74, 8'($urandom));
        // Starts aimed at the reserved top are refused
        for (int r = 8'h78; r < 8'h80; r++) begin
            @(negedge clk);
            addr = 7'(r);
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            repeat (4) @(negedge clk);
            chk(busy === 1'b0 && spi_cfg_if_i.chip_select_low === 1'b1, "reserved start");
        end
        chk(strobes == writes, "one strobe per write");
        end_of_test();
    end
endmodule // spi_config_port_slave_tb
`default_nettype wire
